// ===== inc/tcm_pkg.sv
package tcm_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_OFS    = 8'h00;
	localparam logic [7:0] LEVEL_OFS   = 8'h04;
	localparam logic [7:0] OUTEN_OFS   = 8'h08;
	localparam logic [7:0] CTRL_OFS    = 8'h0C;
	localparam logic [7:0] STAT_OFS    = 8'h10;
	localparam logic [7:0] IRQ_EN_OFS  = 8'h14;
	localparam logic [7:0] IRQ_CLR_OFS = 8'h18;
	localparam logic [7:0] COUNT_OFS   = 8'h1C;
	localparam logic [7:0] RELOAD_OFS  = 8'h20;
	localparam logic [7:0] CAPT_OFS    = 8'h24;
	// ----------------------------------------------------------------
	// Mode register fields
	// ----------------------------------------------------------------
	localparam int MODE_LSB   = 0;
	localparam int EDGE_LSB   = 6;
	localparam int TRIG_LSB   = 8;
	localparam int CCS_BIT    = 12;
	localparam int OPCLK_LSB  = 14;
	localparam int CHAN_BIT   = 3;
	localparam logic [15:0] MODE_WMASK  = 16'hD7CF;
	localparam logic [15:0] MODE_RESET  = 16'h0000;
	localparam logic [15:0] LEVEL_RESET = 16'h0000;
	localparam logic [15:0] OUTEN_RESET = 16'h0000;
	// Status and control bits
	localparam int ST_START = 0;
	localparam int ST_END   = 1;
	localparam int ST_CAPT  = 2;
	localparam int ST_RUN   = 3;
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP  = 1;

	typedef enum logic [2:0] {
		TCM_MD_INTERVAL = 3'b000,
		TCM_MD_CAPTURE  = 3'b010,
		TCM_MD_EVENT    = 3'b011,
		TCM_MD_ONECOUNT = 3'b100,
		TCM_MD_CAPONE   = 3'b110
	} tcm_mode_t;

	typedef enum logic [1:0] {
		TCM_EDGE_FALL = 2'b00,
		TCM_EDGE_RISE = 2'b01,
		TCM_EDGE_LOW  = 2'b10,
		TCM_EDGE_HIGH = 2'b11
	} tcm_edge_t;

	typedef enum logic [2:0] {
		TCM_TRIG_SW   = 3'b000,
		TCM_TRIG_EDGE = 3'b001,
		TCM_TRIG_BOTH = 3'b010
	} tcm_trig_t;
endpackage

// ===== logic/tcm_channel.sv
// Behaviour
// - Edge field 00 picks falling edge, 01 rising edge of input pin.
// - Edge field 10: falling edge starts, rising edge captures (low width).
// - Edge field 11: rising edge starts, falling edge captures (high width).
// - Mode 000x is interval timer, counting down.
// - Mode 010x is capture mode, counting up.
// - Mode 0110 counts external events down; start gives no event or toggle.
// - Mode 100x is one-count mode, counting down.
// - Mode 1100 counts up; start silent; restarts while counting ignored.
// - Interval and capture: low bit 1 raises event and toggles at start.
// - One-count, low bit 0: start while counting ignored, no event.
// - One-count, low bit 1: start while counting restarts and raises event.
// - Level register holds channel bit 3; bits 15 to 4 read zero.
// - Enable register holds channel bit 3; upper bits read zero.
// - Enable 0: timer leaves level alone; software writes reach the pin.
// - Enable 1: timer drives level; software writes to it ignored.
// - Level bit is what the channel output pin shows.
// - Trigger field 10:8 picks software, valid edge, or both edges.
// - Bit 12 picks operation clock or valid input edge as count clock.
`timescale 1ns/1ps
`default_nettype none
module tcm_channel #(
	parameter int CW = 16
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        timer_input_pin,
	output logic             timer_output_pin,
	output logic             irq
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0]   mode_reg;
	logic          output_level_bit;
	logic          output_enable_bit;
	logic [2:0]    irq_status;
	logic [2:0]    irq_enable;
	logic [CW-1:0] count_register;
	logic [CW-1:0] reload;
	logic [CW-1:0] capture;
	logic          running;
	logic [2:0]    pin_sync;

	tcm_pkg::tcm_mode_t mode;
	tcm_pkg::tcm_edge_t edge_sel;
	tcm_pkg::tcm_trig_t trig_sel;
	logic start_event_option;
	logic count_clock_select;
	assign mode = tcm_pkg::tcm_mode_t'(mode_reg[tcm_pkg::MODE_LSB+1 +: 3]);
	assign start_event_option = mode_reg[tcm_pkg::MODE_LSB];
	assign edge_sel = tcm_pkg::tcm_edge_t'(mode_reg[tcm_pkg::EDGE_LSB +: 2]);
	assign trig_sel = tcm_pkg::tcm_trig_t'(mode_reg[tcm_pkg::TRIG_LSB +: 3]);
	assign count_clock_select = mode_reg[tcm_pkg::CCS_BIT];

	// ----------------------------------------------------------------
	// Input pin synchroniser and edges
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync <= 3'h0;
		end else begin
			pin_sync <= {pin_sync[1:0], timer_input_pin};
		end
	end

	logic rise;
	logic fall;
	logic valid_edge;
	logic start_edge;
	logic capt_edge;
	assign rise = pin_sync[1] & ~pin_sync[2];
	assign fall = ~pin_sync[1] & pin_sync[2];

	always_comb begin
		unique case (edge_sel)
			tcm_pkg::TCM_EDGE_FALL: begin
				valid_edge = fall;
				start_edge = fall;
				capt_edge  = fall;
			end
			tcm_pkg::TCM_EDGE_RISE: begin
				valid_edge = rise;
				start_edge = rise;
				capt_edge  = rise;
			end
			tcm_pkg::TCM_EDGE_LOW: begin
				valid_edge = rise | fall;
				start_edge = fall;
				capt_edge  = rise;
			end
			tcm_pkg::TCM_EDGE_HIGH: begin
				valid_edge = rise | fall;
				start_edge = rise;
				capt_edge  = fall;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Trigger selection
	// ----------------------------------------------------------------
	logic sw_start;
	logic sw_stop;
	logic hw_start;
	logic hw_capt;
	logic tick;
	always_comb begin
		hw_start = 1'b0;
		hw_capt  = 1'b0;
		case (trig_sel)
			tcm_pkg::TCM_TRIG_EDGE: begin
				hw_start = valid_edge;
				hw_capt  = valid_edge;
			end
			tcm_pkg::TCM_TRIG_BOTH: begin
				hw_start = start_edge;
				hw_capt  = capt_edge;
			end
			default: begin
				hw_start = 1'b0;
				hw_capt  = 1'b0;
			end
		endcase
	end
	assign tick = count_clock_select ? valid_edge : 1'b1;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic       aw_have;
	logic       w_have;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic       wr_go;
	assign wr_go = aw_have & w_have & ~s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid && !aw_have && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				aw_have       <= 1'b1;
			end
			if (s_axi_wvalid && !w_have && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_have       <= 1'b1;
			end
			if (wr_go) begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_mode;
	logic wr_level;
	logic wr_outen;
	logic wr_ctrl;
	logic wr_en;
	logic wr_clr;
	logic wr_reload;
	assign wr_mode   = wr_go && aw_addr == tcm_pkg::MODE_OFS;
	assign wr_level  = wr_go && aw_addr == tcm_pkg::LEVEL_OFS && w_strb[0];
	assign wr_outen  = wr_go && aw_addr == tcm_pkg::OUTEN_OFS && w_strb[0];
	assign wr_ctrl   = wr_go && aw_addr == tcm_pkg::CTRL_OFS && w_strb[0];
	assign wr_en     = wr_go && aw_addr == tcm_pkg::IRQ_EN_OFS && w_strb[0];
	assign wr_clr    = wr_go && aw_addr == tcm_pkg::IRQ_CLR_OFS && w_strb[0];
	assign wr_reload = wr_go && aw_addr == tcm_pkg::RELOAD_OFS;
	assign sw_start  = wr_ctrl & w_data[tcm_pkg::CTRL_START];
	assign sw_stop   = wr_ctrl & w_data[tcm_pkg::CTRL_STOP];

	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			tcm_pkg::MODE_OFS:    rd_word[15:0] = mode_reg;
			tcm_pkg::LEVEL_OFS:   rd_word[tcm_pkg::CHAN_BIT] = output_level_bit;
			tcm_pkg::OUTEN_OFS:   rd_word[tcm_pkg::CHAN_BIT] = output_enable_bit;
			tcm_pkg::CTRL_OFS:    rd_word = 32'h0000_0000;
			tcm_pkg::STAT_OFS:    rd_word[3:0] = {running, irq_status};
			tcm_pkg::IRQ_EN_OFS:  rd_word[2:0] = irq_enable;
			tcm_pkg::IRQ_CLR_OFS: rd_word = 32'h0000_0000;
			tcm_pkg::COUNT_OFS:   rd_word[CW-1:0] = count_register;
			tcm_pkg::RELOAD_OFS:  rd_word[CW-1:0] = reload;
			tcm_pkg::CAPT_OFS:    rd_word[CW-1:0] = capture;
			default:              rd_word = 32'h0000_0000;
		endcase
	end

	logic rd_map;
	assign rd_map = s_axi_araddr <= tcm_pkg::CAPT_OFS && s_axi_araddr[1:0] == 2'b00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_map ? 2'b00 : 2'b10;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= tcm_pkg::MODE_RESET;
			reload   <= '0;
		end else begin
			if (wr_mode) begin
				mode_reg <= w_data[15:0] & tcm_pkg::MODE_WMASK;
			end
			if (wr_reload) begin
				reload <= w_data[CW-1:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			output_enable_bit <= tcm_pkg::OUTEN_RESET[tcm_pkg::CHAN_BIT];
		end else if (wr_outen) begin
			output_enable_bit <= w_data[tcm_pkg::CHAN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Counter core
	// ----------------------------------------------------------------
	logic start_req;
	logic accept;
	logic loud;
	logic down;
	logic at_end;
	logic ev_start;
	logic ev_end;
	logic ev_capt;
	assign start_req = sw_start | (hw_start & mode != tcm_pkg::TCM_MD_EVENT);
	assign down = mode == tcm_pkg::TCM_MD_INTERVAL
		| mode == tcm_pkg::TCM_MD_EVENT
		| mode == tcm_pkg::TCM_MD_ONECOUNT;
	assign at_end = count_register == '0;

	always_comb begin
		accept = start_req;
		loud   = 1'b0;
		unique case (mode)
			tcm_pkg::TCM_MD_INTERVAL: begin
				loud = start_event_option;
			end
			tcm_pkg::TCM_MD_CAPTURE: begin
				accept = sw_start | (start_req & ~running);
				loud   = start_event_option;
			end
			tcm_pkg::TCM_MD_EVENT: begin
				loud = 1'b0;
			end
			tcm_pkg::TCM_MD_ONECOUNT: begin
				accept = start_req & (~running | start_event_option);
				loud   = running & start_event_option;
			end
			tcm_pkg::TCM_MD_CAPONE: begin
				accept = start_req & ~running;
				loud   = 1'b0;
			end
			default: begin
				accept = 1'b0;
				loud   = 1'b0;
			end
		endcase
	end
	assign ev_start = accept & loud;

	always_comb begin
		ev_end  = 1'b0;
		ev_capt = 1'b0;
		if (running && !accept) begin
			case (mode)
				tcm_pkg::TCM_MD_CAPTURE: ev_capt = hw_capt;
				tcm_pkg::TCM_MD_CAPONE:  ev_capt = hw_capt;
				default: ev_end = tick & at_end & down;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			running        <= 1'b0;
			count_register <= '0;
			capture        <= '0;
		end else if (sw_stop) begin
			running <= 1'b0;
		end else if (accept) begin
			running        <= 1'b1;
			count_register <= down ? reload : '0;
		end else if (ev_capt) begin
			capture        <= count_register;
			count_register <= '0;
			if (mode == tcm_pkg::TCM_MD_CAPONE) begin
				running <= 1'b0;
			end
		end else if (running && tick) begin
			if (!down) begin
				count_register <= count_register + 1'b1;
			end else if (!at_end) begin
				count_register <= count_register - 1'b1;
			end else if (mode == tcm_pkg::TCM_MD_ONECOUNT) begin
				running <= 1'b0;
			end else begin
				count_register <= reload;
			end
		end
	end

	// ----------------------------------------------------------------
	// Output level
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			output_level_bit <= tcm_pkg::LEVEL_RESET[tcm_pkg::CHAN_BIT];
			timer_output_pin <= 1'b0;
		end else begin
			if (output_enable_bit) begin
				if (ev_start || ev_end) begin
					output_level_bit <= ~output_level_bit;
				end
			end else if (wr_level) begin
				output_level_bit <= w_data[tcm_pkg::CHAN_BIT];
			end
			timer_output_pin <= output_level_bit;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic [2:0] ev_vec;
	assign ev_vec = {ev_capt, ev_end, ev_start};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= 3'h0;
			irq_enable <= 3'h0;
			irq        <= 1'b0;
		end else begin
			if (wr_en) begin
				irq_enable <= w_data[2:0];
			end
			irq_status <= (irq_status & ~(wr_clr ? w_data[2:0] : 3'h0)) | ev_vec;
			irq        <= |(irq_status & irq_enable);
		end
	end
endmodule
`default_nettype wire

// ===== bench/tcm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcm_pin_model #(
	parameter int DLY = 7
) (
	input  wire logic        aclk,
	input  wire logic        want,
	input  wire logic        load,
	output logic             pin,
	output logic [31:0]      edges
);
	logic load_q;
	// Source settles a little after the request, off the clock edge
	initial pin = 1'b0;
	always @(want) pin <= #DLY want;
	// Load side counts every level change of the output pin
	initial edges = 32'h0000_0000;
	initial load_q = 1'b0;
	always @(posedge aclk) begin
		load_q <= load;
		if (load !== load_q)
			edges <= edges + 32'h0000_0001;
	end
endmodule
`default_nettype wire

// ===== bench/tcm_channel_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tcm_channel_chk (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	input  wire logic        timer_output_pin
);
	logic [7:0]  wa;
	logic [7:0]  ra;
	logic [31:0] wd;
	logic        bq;
	logic        oe;
	logic        lv;
	logic        known;
	// Shadow of the level and enable bits as software last wrote them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wa <= 8'h00;
			ra <= 8'h00;
			wd <= 32'h0000_0000;
			bq <= 1'b0;
			oe <= 1'b0;
			lv <= 1'b0;
			known <= 1'b1;
		end else begin
			bq <= s_axi_bvalid;
			if (s_axi_awvalid)
				wa <= s_axi_awaddr;
			if (s_axi_wvalid)
				wd <= s_axi_wdata;
			if (s_axi_arvalid)
				ra <= s_axi_araddr;
			if (s_axi_bvalid && !bq && wa == tcm_pkg::OUTEN_OFS) begin
				oe <= wd[3];
				known <= known && !wd[3];
			end
			if (s_axi_bvalid && !bq && wa == tcm_pkg::LEVEL_OFS && !oe) begin
				lv <= wd[3];
				known <= 1'b1;
			end
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held");
	wr_answer_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:2] s_axi_rvalid)
		else $error("read response late");
	ar_with_r_a: assert property ($rose(s_axi_arready) |-> $rose(s_axi_rvalid))
		else $error("arready without rvalid");
	bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
		else $error("write response not okay");
	unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp != 2'b00
		|-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
		else $error("bad error response");
	level_bits_a: assert property (
		s_axi_rvalid && ra == tcm_pkg::LEVEL_OFS |-> (s_axi_rdata & 32'hFFFF_FFF7) == 0)
		else $error("level register spare bits set");
	enable_bits_a: assert property (
		s_axi_rvalid && ra == tcm_pkg::OUTEN_OFS |-> (s_axi_rdata & 32'hFFFF_FFF7) == 0)
		else $error("enable register spare bits set");
	pin_follows_a: assert property (
		known && !oe |-> timer_output_pin == lv)
		else $error("output pin differs from level bit");
endmodule
bind tcm_channel tcm_channel_chk u_chk (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .timer_output_pin);
`default_nettype wire

// ===== bench/timer_channel_mode_output_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_output_ctrl_test;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        lvl = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, tout, irq, tin;
	logic [1:0]  bresp, rresp, gresp;
	logic [31:0] rdata, got, c1, e, edges;
	int          err_total = 0;
	int          cmp_count = 0;
	always #50 aclk = ~aclk;
	tcm_channel dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .timer_input_pin(tin), .timer_output_pin(tout),
		.irq(irq));
	tcm_pin_model pm (.aclk(aclk), .want(lvl), .load(tout), .pin(tin),
		.edges(edges));
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 50);
		bready <= 1'b0;
		if (n == 50) begin
			err_total++;
			$display("BAD %0t write answer missing", $time);
		end
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 50);
		got = rdata;
		gresp = rresp;
		rready <= 1'b0;
		if (n == 50) begin
			err_total++;
			$display("BAD %0t read answer missing", $time);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		rd(a);
		chk(got, x);
	endtask
	task automatic print_verdict;
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#2_000_000;
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict;
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rc(tcm_pkg::MODE_OFS, 32'h0000_0000);
		rc(tcm_pkg::OUTEN_OFS, 32'h0000_0000);
		wr(tcm_pkg::LEVEL_OFS, 32'hFFFF_FFFF);
		rc(tcm_pkg::LEVEL_OFS, 32'h0000_0008);
		chk(tout, 1);
		wr(tcm_pkg::OUTEN_OFS, 32'hFFFF_FFFF);
		rc(tcm_pkg::OUTEN_OFS, 32'h0000_0008);
		wr(tcm_pkg::LEVEL_OFS, 32'h0000_0000);
		rc(tcm_pkg::LEVEL_OFS, 32'h0000_0008);
		rd(8'h40);
		chk(gresp, 2'b10);
		chk(got, 32'h0000_0000);
		// Start with and without the start event, output enabled
		wr(tcm_pkg::RELOAD_OFS, 32'h0000_FFFF);
		wr(tcm_pkg::IRQ_EN_OFS, 32'h0000_0001);
		for (e = 0; e < 2; e++) begin
			wr(tcm_pkg::MODE_OFS, e);
			c1 = edges;
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0001);
			repeat (3) @(posedge aclk);
			chk(edges - c1, e);
			chk(irq, e);
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0002);
		end
		wr(tcm_pkg::IRQ_EN_OFS, 32'h0000_0000);
		repeat (2) @(posedge aclk);
		chk(irq, 0);
		wr(tcm_pkg::IRQ_CLR_OFS, 32'h0000_000F);
		rc(tcm_pkg::STAT_OFS, 32'h0000_0000);
		// Direction of count: interval down, capture up
		for (e = 0; e < 2; e++) begin
			wr(tcm_pkg::MODE_OFS, e * 4);
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0001);
			rd(tcm_pkg::COUNT_OFS);
			c1 = got;
			rd(tcm_pkg::COUNT_OFS);
			chk(e ? got > c1 : got < c1, 1);
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0002);
		end
		// One-count: restart while counting, quiet and loud
		for (e = 8; e < 10; e++) begin
			wr(tcm_pkg::MODE_OFS, e);
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0001);
			wr(tcm_pkg::IRQ_CLR_OFS, 32'h0000_000F);
			rd(tcm_pkg::COUNT_OFS);
			c1 = got;
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0001);
			rd(tcm_pkg::STAT_OFS);
			chk(got[0], e - 8);
			rd(tcm_pkg::COUNT_OFS);
			chk(got > c1, e - 8);
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0002);
		end
		// Event counter on the pin, falling then rising valid edge
		for (e = 0; e < 2; e++) begin
			wr(tcm_pkg::MODE_OFS, 32'h0000_1006 | (e << 6));
			wr(tcm_pkg::IRQ_CLR_OFS, 32'h0000_000F);
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0001);
			rd(tcm_pkg::COUNT_OFS);
			c1 = got;
			lvl <= 1'b1;
			repeat (6) @(posedge aclk);
			rc(tcm_pkg::COUNT_OFS, c1 - e);
			lvl <= 1'b0;
			repeat (6) @(posedge aclk);
			rc(tcm_pkg::COUNT_OFS, c1 - 1);
			rd(tcm_pkg::STAT_OFS);
			chk(got[0], 0);
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0002);
		end
		// Width measurement: low width then high width, both edges
		for (e = 2; e < 4; e++) begin
			wr(tcm_pkg::MODE_OFS, 32'h0000_020C | (e << 6));
			lvl <= ~e[0];
			rc(tcm_pkg::MODE_OFS, 32'h0000_020C | (e << 6));
			wr(tcm_pkg::IRQ_CLR_OFS, 32'h0000_000F);
			rc(tcm_pkg::STAT_OFS, 32'h0000_0000);
			lvl <= e[0];
			repeat (6) @(posedge aclk);
			rd(tcm_pkg::STAT_OFS);
			chk(got[3:0], 32'h0000_0008);
			lvl <= ~e[0];
			repeat (6) @(posedge aclk);
			rd(tcm_pkg::STAT_OFS);
			chk(got[2], 1);
			wr(tcm_pkg::CTRL_OFS, 32'h0000_0002);
		end
		// Capture mode: one rising edge starts, the next one captures
		wr(tcm_pkg::MODE_OFS, 32'h0000_0144);
		wr(tcm_pkg::IRQ_CLR_OFS, 32'h0000_000F);
		lvl <= 1'b1;
		repeat (4) @(posedge aclk);
		lvl <= 1'b0;
		repeat (4) @(posedge aclk);
		lvl <= 1'b1;
		repeat (4) @(posedge aclk);
		rc(tcm_pkg::CAPT_OFS, 32'h0000_0007);
		rc(tcm_pkg::STAT_OFS, 32'h0000_000C);
		wr(tcm_pkg::CTRL_OFS, 32'h0000_0002);
		// Interval with a short reload: count end flags and toggles
		wr(tcm_pkg::RELOAD_OFS, 32'h0000_0003);
		wr(tcm_pkg::MODE_OFS, 32'h0000_0000);
		wr(tcm_pkg::IRQ_CLR_OFS, 32'h0000_000F);
		c1 = edges;
		wr(tcm_pkg::CTRL_OFS, 32'h0000_0001);
		repeat (16) @(posedge aclk);
		wr(tcm_pkg::CTRL_OFS, 32'h0000_0002);
		rc(tcm_pkg::STAT_OFS, 32'h0000_0002);
		chk(edges - c1 >= 32'h0000_0002, 1);
		print_verdict;
	end
endmodule
`default_nettype wire
